/* cbd_top.sv */
// Capacitive / inductive button detector: linearisation, counts filter, reference tracking and detection.
// Assumes raw samples arrive with a valid/ready handshake and the register port of the system bus.
//
// Contract
// - Linearised count is 3276750 over raw count; later stages use only it.
// - Linearised counts pass a low-pass IIR set by the counts coefficient.
// - Delta equals reference minus filtered counts and is stored for readout.
// - While neither active nor frozen, the reference slowly follows filtered counts.
// - Delta above button threshold enters active state and sets its status bit.
// - Reference holds while active or while delta exceeds the freeze threshold.
// - Normal coefficient in high-accuracy/normal modes, low-power one in low/ultra-low.
// - Negative delta never activates; beyond fast bound, reference uses fast coefficient.
// - Two-sided bit disables fast recovery; invert bit flips the delta sign.
// - Reseed loads filtered counts and reference with the latest count.
// - Active for the stuck timeout triggers automatic reseed; zero disables it.
// - Host sets the command reseed bit; the block then reseeds.
// - Self-capacitive or inductive sensing chosen by a field in settings B.
// - Button and movement paths keep separate references and deltas.
`timescale 1ns/1ps
module cbd_top (
	// Clock and reset
	input  wire logic                            CORE_CLK,
	input  wire logic                            RST_B,
	// Register port
	input  wire logic [cbd_pkg::ADDR_W-1:0]      REG_ADDR,
	input  wire logic [cbd_pkg::DATA_W-1:0]      REG_WDATA,
	input  wire logic                            REG_WR,
	input  wire logic                            REG_RD,
	output logic      [cbd_pkg::DATA_W-1:0]      REG_RDATA,
	// Raw sample stream
	input  wire logic                            SAMPLE_VALID,
	input  wire logic [cbd_pkg::RAW_W-1:0]       SAMPLE_RAW,
	output logic                                 SAMPLE_READY,
	// Front-end control and events
	output logic                                 SENSE_MODE,
	output logic                                 BUTTON_ACTIVE,
	output logic                                 REF_FROZEN,
	output logic                                 MOVE_ENTERED,
	output logic                                 MOVE_EXITED
);
	typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_COUNTS, ST_REF} cbd_state_t;

	// Reset release
	logic                                  rst_meta;
	logic                                  rst_n;

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Settings
	logic                                  two_sided;
	logic                                  invert;
	cbd_pkg::cbd_sense_t                   sense_mode;
	logic [cbd_pkg::COEF_W-1:0]            cnt_coef;
	logic [cbd_pkg::COEF_W-1:0]            ref_coef;
	logic [cbd_pkg::COEF_W-1:0]            lp_coef;
	logic [cbd_pkg::COEF_W-1:0]            fast_coef;
	cbd_pkg::cbd_power_t                   power_mode;
	logic [cbd_pkg::THR_W-1:0]             btn_thr;
	logic [cbd_pkg::THR_W-1:0]             frz_thr;
	logic [cbd_pkg::THR_W-1:0]             fast_bnd;
	logic [cbd_pkg::THR_W-1:0]             timeout;
	logic [cbd_pkg::THR_W-1:0]             mov_thr;

	// Processing state
	cbd_state_t                            state;
	cbd_state_t                            next_state;
	logic [cbd_pkg::CNT_W-1:0]             lin;
	logic [cbd_pkg::CNT_W-1:0]             counts;
	logic [cbd_pkg::CNT_W-1:0]             reference;
	logic signed [cbd_pkg::DLT_W-1:0]      delta;
	logic                                  seeded;
	logic                                  have_lin;
	logic                                  active;
	logic                                  frozen;
	logic [cbd_pkg::THR_W-1:0]             stuck;
	logic                                  reseed_pending;
	logic signed [cbd_pkg::DLT_W-1:0]      mov_delta;
	logic                                  mov_enter;
	logic                                  mov_exit;

	// Register decode
	wire wr_cmd = REG_WR && REG_ADDR == cbd_pkg::A_SYS_CMD;
	wire wr_set_a = REG_WR && REG_ADDR == cbd_pkg::A_SET_A;
	wire wr_set_b = REG_WR && REG_ADDR == cbd_pkg::A_SET_B;
	wire wr_coef = REG_WR && REG_ADDR == cbd_pkg::A_COEF;
	wire wr_power = REG_WR && REG_ADDR == cbd_pkg::A_POWER;
	wire wr_btn_thr = REG_WR && REG_ADDR == cbd_pkg::A_BTN_THR;
	wire wr_frz_thr = REG_WR && REG_ADDR == cbd_pkg::A_FRZ_THR;
	wire wr_fast_bnd = REG_WR && REG_ADDR == cbd_pkg::A_FAST_BND;
	wire wr_timeout = REG_WR && REG_ADDR == cbd_pkg::A_TIMEOUT;
	wire wr_mov_thr = REG_WR && REG_ADDR == cbd_pkg::A_MOV_THR;
	wire host_reseed = wr_cmd && REG_WDATA[cbd_pkg::B_RESEED];

	// Status word
	wire [cbd_pkg::DATA_W-1:0] status_word = cbd_pkg::DATA_W'({reseed_pending, mov_exit, mov_enter, frozen, active});

	// Read selection; unmapped addresses read as zero
	wire [cbd_pkg::DATA_W-1:0] next_rdata =
		(REG_ADDR == cbd_pkg::A_SYS_CMD)   ? cbd_pkg::DATA_W'(reseed_pending) :
		(REG_ADDR == cbd_pkg::A_SET_A)     ? cbd_pkg::DATA_W'({invert, two_sided}) :
		(REG_ADDR == cbd_pkg::A_SET_B)     ? cbd_pkg::DATA_W'(sense_mode) :
		(REG_ADDR == cbd_pkg::A_COEF)      ? cbd_pkg::DATA_W'({fast_coef, lp_coef, ref_coef, cnt_coef}) :
		(REG_ADDR == cbd_pkg::A_POWER)     ? cbd_pkg::DATA_W'(power_mode) :
		(REG_ADDR == cbd_pkg::A_BTN_THR)   ? cbd_pkg::DATA_W'(btn_thr) :
		(REG_ADDR == cbd_pkg::A_FRZ_THR)   ? cbd_pkg::DATA_W'(frz_thr) :
		(REG_ADDR == cbd_pkg::A_FAST_BND)  ? cbd_pkg::DATA_W'(fast_bnd) :
		(REG_ADDR == cbd_pkg::A_TIMEOUT)   ? cbd_pkg::DATA_W'(timeout) :
		(REG_ADDR == cbd_pkg::A_MOV_THR)   ? cbd_pkg::DATA_W'(mov_thr) :
		(REG_ADDR == cbd_pkg::A_STATUS)    ? status_word :
		(REG_ADDR == cbd_pkg::A_COUNTS)    ? cbd_pkg::DATA_W'(counts) :
		(REG_ADDR == cbd_pkg::A_REF)       ? cbd_pkg::DATA_W'(reference) :
		(REG_ADDR == cbd_pkg::A_DELTA)     ? cbd_pkg::DATA_W'(delta) :
		(REG_ADDR == cbd_pkg::A_LIN)       ? cbd_pkg::DATA_W'(lin) :
		(REG_ADDR == cbd_pkg::A_MOV_DELTA) ? cbd_pkg::DATA_W'(mov_delta) :
		'0;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			two_sided <= 1'b0;
			invert <= 1'b0;
			sense_mode <= cbd_pkg::SM_SELF_CAP;
			cnt_coef <= cbd_pkg::RST_CNT_COEF;
			ref_coef <= cbd_pkg::RST_REF_COEF;
			lp_coef <= cbd_pkg::RST_LP_COEF;
			fast_coef <= cbd_pkg::RST_FAST_COEF;
			power_mode <= cbd_pkg::PM_NORMAL;
			btn_thr <= cbd_pkg::RST_BTN_THR;
			frz_thr <= cbd_pkg::RST_FRZ_THR;
			fast_bnd <= cbd_pkg::RST_FAST_BND;
			timeout <= cbd_pkg::RST_TIMEOUT;
			mov_thr <= cbd_pkg::RST_MOV_THR;
		end else begin
			if (wr_set_a) begin
				two_sided <= REG_WDATA[cbd_pkg::B_TWO_SIDED];
				invert <= REG_WDATA[cbd_pkg::B_INVERT];
			end
			if (wr_set_b) begin
				sense_mode <= cbd_pkg::cbd_sense_t'(REG_WDATA[cbd_pkg::B_SENSE_MODE]);
			end
			if (wr_coef) begin
				cnt_coef <= REG_WDATA[cbd_pkg::F_CNT_COEF +: cbd_pkg::COEF_W];
				ref_coef <= REG_WDATA[cbd_pkg::F_REF_COEF +: cbd_pkg::COEF_W];
				lp_coef <= REG_WDATA[cbd_pkg::F_LP_COEF +: cbd_pkg::COEF_W];
				fast_coef <= REG_WDATA[cbd_pkg::F_FAST_COEF +: cbd_pkg::COEF_W];
			end
			if (wr_power) begin
				power_mode <= cbd_pkg::cbd_power_t'(REG_WDATA[1:0]);
			end
			if (wr_btn_thr) begin
				btn_thr <= REG_WDATA[cbd_pkg::THR_W-1:0];
			end
			if (wr_frz_thr) begin
				frz_thr <= REG_WDATA[cbd_pkg::THR_W-1:0];
			end
			if (wr_fast_bnd) begin
				fast_bnd <= REG_WDATA[cbd_pkg::THR_W-1:0];
			end
			if (wr_timeout) begin
				timeout <= REG_WDATA[cbd_pkg::THR_W-1:0];
			end
			if (wr_mov_thr) begin
				mov_thr <= REG_WDATA[cbd_pkg::THR_W-1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= '0;
		end else begin
			REG_RDATA <= REG_RD ? next_rdata : '0;
		end
	end

	// Divider
	cbd_div_if div ();

	cbd_divider u_div (
		.clk   (CORE_CLK),
		.rst_n (rst_n),
		.d     (div)
	);

	wire take_sample = state == ST_IDLE && SAMPLE_VALID;
	assign div.start = take_sample;
	assign div.denom = SAMPLE_RAW;

	// Sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE:   next_state = take_sample ? ST_DIV : ST_IDLE;
			ST_DIV:    next_state = div.done ? ST_COUNTS : ST_DIV;
			ST_COUNTS: next_state = ST_REF;
			ST_REF:    next_state = ST_IDLE;
		endcase
	end

	// Detection math on the freshly filtered counts
	wire signed [cbd_pkg::DLT_W-1:0] raw_delta = signed'({1'b0, reference}) - signed'({1'b0, counts});
	wire signed [cbd_pkg::DLT_W-1:0] eff_delta = invert ? -raw_delta : raw_delta;
	wire signed [cbd_pkg::DLT_W-1:0] neg_mag = -eff_delta;
	// Only a positive delta can cross the threshold, so negative swings never activate
	wire next_active = eff_delta > signed'(cbd_pkg::DLT_W'(btn_thr));
	wire next_frozen = eff_delta > signed'(cbd_pkg::DLT_W'(frz_thr));
	wire fast_recover = !two_sided && eff_delta < 0 && neg_mag > signed'(cbd_pkg::DLT_W'(fast_bnd));
	wire low_power = power_mode == cbd_pkg::PM_LOW || power_mode == cbd_pkg::PM_ULTRA_LOW;
	wire [cbd_pkg::COEF_W-1:0] slow_coef = low_power ? lp_coef : ref_coef;
	wire hold_ref = next_active || next_frozen;
	wire [cbd_pkg::CNT_W-1:0] next_reference =
		fast_recover ? cbd_pkg::iir(reference, counts, fast_coef) :
		hold_ref     ? reference :
		cbd_pkg::iir(reference, counts, slow_coef);

	// Stuck detection counts processed samples spent active
	wire [cbd_pkg::THR_W-1:0] next_stuck = stuck + 16'h0001;
	wire stuck_hit = state == ST_REF && next_active && timeout != '0 && next_stuck >= timeout;
	// Reseed waits for idle so it never tears a sample mid-flight; a new request beats the clear
	wire apply_reseed = reseed_pending && state == ST_IDLE && have_lin;
	wire reseed_set = host_reseed || stuck_hit;
	wire motion_update = state == ST_REF;

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			SAMPLE_READY <= 1'b0;
			lin <= '0;
			have_lin <= 1'b0;
			seeded <= 1'b0;
			counts <= '0;
			reference <= '0;
			delta <= '0;
			active <= 1'b0;
			frozen <= 1'b0;
			stuck <= '0;
			reseed_pending <= 1'b0;
		end else begin
			state <= next_state;
			SAMPLE_READY <= next_state == ST_IDLE;
			reseed_pending <= reseed_set || (reseed_pending && !apply_reseed);
			if (state == ST_DIV && div.done) begin
				lin <= div.quot;
				have_lin <= 1'b1;
			end
			if (apply_reseed) begin
				counts <= lin;
				reference <= lin;
				active <= 1'b0;
				stuck <= '0;
			end else if (state == ST_COUNTS) begin
				// First sample seeds the filter so it does not ramp from zero
				counts <= seeded ? cbd_pkg::iir(counts, lin, cnt_coef) : lin;
				if (!seeded) begin
					reference <= lin;
				end
				seeded <= 1'b1;
			end else if (state == ST_REF) begin
				delta <= eff_delta;
				active <= next_active;
				frozen <= next_frozen;
				reference <= next_reference;
				stuck <= (next_active && !stuck_hit) ? next_stuck : '0;
			end
		end
	end

	// Movement path with its own reference
	cbd_motion u_motion (
		.clk        (CORE_CLK),
		.rst_n      (rst_n),
		.update     (motion_update),
		.counts     (counts),
		.ref_coeff  (slow_coef),
		.fast_coeff (fast_coef),
		.threshold  (mov_thr),
		.invert     (invert),
		.delta      (mov_delta),
		.entered    (mov_enter),
		.exited     (mov_exit)
	);

	// Pin outputs, registered
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			SENSE_MODE <= 1'b0;
			BUTTON_ACTIVE <= 1'b0;
			REF_FROZEN <= 1'b0;
			MOVE_ENTERED <= 1'b0;
			MOVE_EXITED <= 1'b0;
		end else begin
			SENSE_MODE <= sense_mode == cbd_pkg::SM_INDUCTIVE;
			BUTTON_ACTIVE <= active;
			REF_FROZEN <= frozen;
			MOVE_ENTERED <= mov_enter;
			MOVE_EXITED <= mov_exit;
		end
	end
endmodule

/* cbd_pkg.sv */
// Shared constants, register map, field layout and filter arithmetic for the button detector.
// Assumes a 32-bit register port with byte addresses and one system clock.
package cbd_pkg;

	// Data widths
	localparam int CNT_W = 24;
	localparam int DLT_W = CNT_W + 1;
	localparam int RAW_W = 16;
	localparam int NUM_W = 22;
	localparam int THR_W = 16;
	localparam int COEF_W = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Linearisation numerator
	localparam logic [NUM_W-1:0] LIN_NUMERATOR = 22'h31FFCE;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] A_SYS_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] A_SET_A = 8'h04;
	localparam logic [ADDR_W-1:0] A_SET_B = 8'h08;
	localparam logic [ADDR_W-1:0] A_COEF = 8'h0C;
	localparam logic [ADDR_W-1:0] A_POWER = 8'h10;
	localparam logic [ADDR_W-1:0] A_BTN_THR = 8'h14;
	localparam logic [ADDR_W-1:0] A_FRZ_THR = 8'h18;
	localparam logic [ADDR_W-1:0] A_FAST_BND = 8'h1C;
	localparam logic [ADDR_W-1:0] A_TIMEOUT = 8'h20;
	localparam logic [ADDR_W-1:0] A_MOV_THR = 8'h24;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h28;
	localparam logic [ADDR_W-1:0] A_COUNTS = 8'h2C;
	localparam logic [ADDR_W-1:0] A_REF = 8'h30;
	localparam logic [ADDR_W-1:0] A_DELTA = 8'h34;
	localparam logic [ADDR_W-1:0] A_LIN = 8'h38;
	localparam logic [ADDR_W-1:0] A_MOV_DELTA = 8'h3C;

	// Field positions
	localparam int B_RESEED = 0;
	localparam int B_TWO_SIDED = 0;
	localparam int B_INVERT = 1;
	localparam int B_SENSE_MODE = 0;
	localparam int F_CNT_COEF = 0;
	localparam int F_REF_COEF = 4;
	localparam int F_LP_COEF = 8;
	localparam int F_FAST_COEF = 12;
	localparam int B_ST_ACTIVE = 0;
	localparam int B_ST_FROZEN = 1;
	localparam int B_ST_ENTER = 2;
	localparam int B_ST_EXIT = 3;
	localparam int B_ST_RESEED = 4;

	// Reset values
	localparam logic [COEF_W-1:0] RST_CNT_COEF = 4'h2;
	localparam logic [COEF_W-1:0] RST_REF_COEF = 4'h7;
	localparam logic [COEF_W-1:0] RST_LP_COEF = 4'h9;
	localparam logic [COEF_W-1:0] RST_FAST_COEF = 4'h2;
	localparam logic [THR_W-1:0] RST_BTN_THR = 16'h0064;
	localparam logic [THR_W-1:0] RST_FRZ_THR = 16'h0032;
	localparam logic [THR_W-1:0] RST_FAST_BND = 16'h0064;
	localparam logic [THR_W-1:0] RST_TIMEOUT = 16'h0000;
	localparam logic [THR_W-1:0] RST_MOV_THR = 16'h0014;

	typedef enum logic [1:0] {PM_HIGH_ACC, PM_NORMAL, PM_LOW, PM_ULTRA_LOW} cbd_power_t;
	typedef enum logic {SM_SELF_CAP, SM_INDUCTIVE} cbd_sense_t;

	// First-order low-pass step: old + ((in - old) >>> k)
	function automatic logic [CNT_W-1:0] iir(input logic [CNT_W-1:0] old, input logic [CNT_W-1:0] inp,
			input logic [COEF_W-1:0] k);
		logic signed [CNT_W:0] diff;
		logic signed [CNT_W:0] step;
		logic [CNT_W:0] sum;
		diff = signed'({1'b0, inp}) - signed'({1'b0, old});
		step = diff >>> k;
		sum = {1'b0, old} + unsigned'(step);
		iir = sum[CNT_W-1:0];
	endfunction

endpackage

/* cbd_div_if.sv */
// Handshake between the sample sequencer and the reciprocal divider.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface cbd_div_if;
	logic                            start;
	logic [cbd_pkg::RAW_W-1:0]       denom;
	logic                            busy;
	logic                            done;
	logic [cbd_pkg::CNT_W-1:0]       quot;

	modport master (output start, output denom, input busy, input done, input quot);
	modport slave (input start, input denom, output busy, output done, output quot);
endinterface

/* cbd_divider.sv */
// Restoring divider forming the fixed numerator over the raw count, one quotient bit a cycle.
// Assumes start is only raised while busy is low; denom must hold for that one cycle only.
`timescale 1ns/1ps
module cbd_divider (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Division handshake
	cbd_div_if.slave  d
);
	logic [cbd_pkg::RAW_W-1:0]   den;
	logic [cbd_pkg::RAW_W:0]     rem;
	logic [cbd_pkg::NUM_W-1:0]   quo;
	logic [4:0]                  cnt;
	logic                        busy;
	logic                        done;
	wire  [cbd_pkg::RAW_W:0]     trial = {rem[cbd_pkg::RAW_W-1:0], cbd_pkg::LIN_NUMERATOR[cnt]};
	wire                         fits = trial >= {1'b0, den};
	wire  [cbd_pkg::RAW_W:0]     rest = fits ? trial - {1'b0, den} : trial;

	assign d.busy = busy;
	assign d.done = done;
	assign d.quot = cbd_pkg::CNT_W'(quo);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			den <= '0;
			rem <= '0;
			quo <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (d.start && !busy) begin
				// A zero raw count would divide by zero; saturate instead
				if (d.denom == '0) begin
					quo <= '1;
					done <= 1'b1;
				end else begin
					den <= d.denom;
					rem <= '0;
					quo <= '0;
					cnt <= 5'(cbd_pkg::NUM_W - 1);
					busy <= 1'b1;
				end
			end else if (busy) begin
				rem <= rest;
				quo <= {quo[cbd_pkg::NUM_W-2:0], fits};
				if (cnt == '0) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt <= cnt - 5'h01;
				end
			end
		end
	end
endmodule

/* cbd_motion.sv */
// Movement event path: its own reference and delta, never touching the button path's state.
// Assumes update pulses once per processed sample with settled filtered counts.
`timescale 1ns/1ps
module cbd_motion (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// Sample input
	input  wire logic                              update,
	input  wire logic [cbd_pkg::CNT_W-1:0]         counts,
	// Settings
	input  wire logic [cbd_pkg::COEF_W-1:0]        ref_coeff,
	input  wire logic [cbd_pkg::COEF_W-1:0]        fast_coeff,
	input  wire logic [cbd_pkg::THR_W-1:0]         threshold,
	input  wire logic                              invert,
	// Results
	output logic signed [cbd_pkg::DLT_W-1:0]       delta,
	output logic                                   entered,
	output logic                                   exited
);
	logic [cbd_pkg::CNT_W-1:0]            reference;
	logic                                 seeded;
	wire  signed [cbd_pkg::DLT_W-1:0]     raw_delta = signed'({1'b0, reference}) - signed'({1'b0, counts});
	wire  signed [cbd_pkg::DLT_W-1:0]     eff_delta = !seeded ? '0 : (invert ? -raw_delta : raw_delta);
	wire  signed [cbd_pkg::DLT_W-1:0]     thr = signed'(cbd_pkg::DLT_W'(threshold));
	wire                                  pos_hit = eff_delta > thr;
	wire                                  neg_hit = -eff_delta > thr;
	wire  [cbd_pkg::COEF_W-1:0]           coeff = (pos_hit || neg_hit) ? fast_coeff : ref_coeff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reference <= '0;
			seeded <= 1'b0;
			delta <= '0;
			entered <= 1'b0;
			exited <= 1'b0;
		end else if (update) begin
			// Never halted: fast coefficient while delta is beyond the threshold either way, regular otherwise
			reference <= seeded ? cbd_pkg::iir(reference, counts, coeff) : counts;
			seeded <= 1'b1;
			delta <= eff_delta;
			entered <= pos_hit;
			exited <= neg_hit;
		end
	end
endmodule

/* cbd_monitor.sv */
// Port-level checks for the button detector top module.
// Assumes it is bound to every cbd_top instance and sees only its ports.
`timescale 1ns/1ps
module cbd_monitor (
	// Clock and reset
	input  wire logic                        CORE_CLK,
	input  wire logic                        RST_B,
	// Register port
	input  wire logic [cbd_pkg::ADDR_W-1:0]  REG_ADDR,
	input  wire logic [cbd_pkg::DATA_W-1:0]  REG_WDATA,
	input  wire logic                        REG_WR,
	input  wire logic                        REG_RD,
	input  wire logic [cbd_pkg::DATA_W-1:0]  REG_RDATA,
	// Samples and events
	input  wire logic                        SAMPLE_VALID,
	input  wire logic                        SAMPLE_READY,
	input  wire logic                        SENSE_MODE,
	input  wire logic                        BUTTON_ACTIVE,
	input  wire logic                        REF_FROZEN,
	input  wire logic                        MOVE_ENTERED,
	input  wire logic                        MOVE_EXITED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data not zero outside read answer");
	a_ready_drop: assert property (SAMPLE_VALID && SAMPLE_READY |=> !SAMPLE_READY)
		else $error("ready stayed high after a taken sample");
	a_ready_back: assert property ($fell(SAMPLE_READY) |-> ##[1:40] SAMPLE_READY)
		else $error("sample processing did not finish");
	a_sense_write: assert property (REG_WR && REG_ADDR == 8'h08 |=> ##1 SENSE_MODE == $past(REG_WDATA[0], 2))
		else $error("sense mode pin does not follow settings B");
	a_sense_read: assert property (REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA == {31'h0, SENSE_MODE})
		else $error("settings B read differs from sense mode pin");
	a_active_frozen: assert property ($rose(BUTTON_ACTIVE) |-> REF_FROZEN)
		else $error("button active without frozen reference");
	a_status_active: assert property (REG_RD && REG_ADDR == 8'h28 |=> REG_RDATA[0] == BUTTON_ACTIVE)
		else $error("status active bit differs from pin");
	a_move_apart: assert property (!(MOVE_ENTERED && MOVE_EXITED))
		else $error("movement enter and exit both set");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR >= 8'h40 |=> REG_RDATA == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind cbd_top cbd_monitor mon (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID),
	.SAMPLE_READY(SAMPLE_READY), .SENSE_MODE(SENSE_MODE), .BUTTON_ACTIVE(BUTTON_ACTIVE),
	.REF_FROZEN(REF_FROZEN), .MOVE_ENTERED(MOVE_ENTERED), .MOVE_EXITED(MOVE_EXITED));

/* cbd_electrode.sv */
// Sensing electrode front end: offers raw counts over valid/ready.
// Assumes one caller at a time and the core clock.
`timescale 1ns/1ps
module cbd_electrode (
	// Clock
	input  wire logic                        clk,
	// Sample stream
	output logic                             valid,
	output logic      [cbd_pkg::RAW_W-1:0]   raw,
	input  wire logic                        ready
);
	initial begin
		valid = 1'b0;
		raw = 16'hA5A5;
	end
	// Raw bus is scrambled after the take so a stale value cannot pass as held
	task automatic offer(input logic [cbd_pkg::RAW_W-1:0] r, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge clk);
		valid <= 1'b1;
		raw <= r;
		for (n = 0; n < 100 && !ok; n++) begin
			#1;
			ok = (ready === 1'b1);
			@(posedge clk);
		end
		valid <= 1'b0;
		raw <= ~r;
	endtask
endmodule

/* capacitive_button_detector_bench.sv */
// Self-checking bench for the button detector top.
// Assumes the electrode model feeds samples; registers use one-cycle strobes.
`timescale 1ns/1ps
module capacitive_button_detector_bench;
	logic                         clk = 1'b0;
	logic                         rst_b = 1'b0;
	logic [cbd_pkg::ADDR_W-1:0]   addr = 8'h00;
	logic [cbd_pkg::DATA_W-1:0]   wdata = 32'h0;
	logic                         wr = 1'b0;
	logic                         rd = 1'b0;
	logic [cbd_pkg::DATA_W-1:0]   rdata;
	logic                         s_valid;
	logic [cbd_pkg::RAW_W-1:0]    s_raw;
	logic                         s_ready;
	logic                         sense;
	logic                         active;
	logic                         frozen;
	logic                         m_enter;
	logic                         m_exit;
	logic [cbd_pkg::DATA_W-1:0]   q;
	bit                           ok;
	int                           bad_count = 0;
	int                           checks = 0;
	logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h40};
	logic [31:0] rv [12] = '{0, 0, 0, 32'h2972, 1, 32'h64, 32'h32, 32'h64, 0, 32'h14, 0, 0};
	always #2 clk = ~clk;
	cbd_top dut (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .SAMPLE_VALID(s_valid), .SAMPLE_RAW(s_raw), .SAMPLE_READY(s_ready),
		.SENSE_MODE(sense), .BUTTON_ACTIVE(active), .REF_FROZEN(frozen), .MOVE_ENTERED(m_enter), .MOVE_EXITED(m_exit));
	cbd_electrode sensor (.clk(clk), .valid(s_valid), .raw(s_raw), .ready(s_ready));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rreg(a, q);
		chk_reg(q, exp);
	endtask
	// Waits for the sequencer to go idle, then two more edges for the event pins
	task automatic sample(input logic [15:0] r);
		int n;
		sensor.offer(r, ok);
		repeat (2) @(posedge clk);
		for (n = 0; n < 60; n++) begin
			#1;
			if (s_ready === 1'b1)
				break;
			@(posedge clk);
		end
		if (!ok || s_ready !== 1'b1) begin
			bad_count++;
			final_report();
		end else begin
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	initial begin
		int i;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 12; i++)
			rchk(ra[i], rv[i]);
		$display("reset values done");
		// Counts filter off, slow reference, low-power coefficient kept above normal
		wreg(8'h0C, 32'h2FE0);
		sample(16'd100);
		rchk(8'h38, 32'h7FFF);
		rchk(8'h2C, 32'h7FFF);
		rchk(8'h34, 32'h0);
		sample(16'd110);
		rchk(8'h34, 32'h0BA3);
		chk_pin(active, 1'b1);
		chk_pin(frozen, 1'b1);
		chk_pin(m_enter, 1'b1);
		rchk(8'h30, 32'h7FFF);
		$display("activation done");
		wreg(8'h00, 32'h1);
		repeat (4) @(posedge clk);
		rchk(8'h30, 32'h745C);
		rchk(8'h2C, 32'h745C);
		rreg(8'h28, q);
		chk_pin(q[0], 1'b0);
		$display("reseed done");
		sample(16'd90);
		chk_pin(active, 1'b0);
		rchk(8'h34, 32'hFFFFE624);
		rchk(8'h30, 32'h7AD3);
		// Movement reference has drifted on its own, so its delta differs from the button delta
		chk_pin(m_exit, 1'b1);
		rchk(8'h3C, 32'hFFFFEEDE);
		wreg(8'h04, 32'h2);
		sample(16'd110);
		chk_pin(active, 1'b0);
		rchk(8'h34, 32'hFFFFF989);
		chk_pin(m_enter, 1'b0);
		wreg(8'h04, 32'h1);
		sample(16'd90);
		rchk(8'h30, 32'h7935);
		$display("direction done");
		wreg(8'h04, 32'h0);
		wreg(8'h20, 32'h1);
		sample(16'd110);
		sample(16'd110);
		repeat (4) @(posedge clk);
		rchk(8'h30, 32'h745C);
		$display("stuck timeout done");
		// Small coefficients so the low-power one visibly differs; fast recovery kept off
		wreg(8'h0C, 32'h2210);
		wreg(8'h04, 32'h1);
		wreg(8'h10, 32'h2);
		sample(16'd109);
		rchk(8'h30, 32'h74A0);
		$display("power mode done");
		wreg(8'h08, 32'h1);
		repeat (3) @(posedge clk);
		#1 chk_pin(sense, 1'b1);
		rchk(8'h08, 32'h1);
		$display("sense mode done");
		// A zero raw count must saturate rather than divide by zero
		sample(16'd0);
		rchk(8'h38, 32'h003FFFFF);
		$display("zero raw done");
		final_report();
	end
endmodule
